// >>> sfe_pkg.sv
// Package with opcodes, identity values and timing counts of the serial flash sequencer
// Summary of operation
// - 20h plus address clears one 4 kB region
// - D8h plus address clears one 64 kB region
// - C7h alone clears the whole array
// - Erase refused unless write enable latch set
// - Select must rise right after final byte
// - Valid erase starts timed cycle, busy flag held
// - Status read still answers during erase cycle
// - Erase completion clears write enable latch
// - Protected targets are never erased
// - B9h enters sleep after entry delay
// - Sleep ignores everything except ABh
// - Reset always comes up awake
// - Sleep request refused while cycle runs
// - ABh alone wakes after wake delay
// - ABh plus three dummies repeats device byte
// - ABh with readout waits longer wake delay
// - ABh ignored while busy
// - 90h returns maker/device, order by address bit
// - 9Fh returns maker, type, capacity bytes
// - Input bits sampled on rising link clock
// - Data read ignored while busy
package sfe_pkg;
	localparam logic [7:0] OP_WREN = 8'h06;
	localparam logic [7:0] OP_RDSR = 8'h05;
	localparam logic [7:0] OP_READ = 8'h03;
	localparam logic [7:0] OP_SMALL = 8'h20;
	localparam logic [7:0] OP_LARGE = 8'hD8;
	localparam logic [7:0] OP_WHOLE = 8'hC7;
	localparam logic [7:0] OP_SLEEP = 8'hB9;
	localparam logic [7:0] OP_WAKE = 8'hAB;
	localparam logic [7:0] OP_MFDEV = 8'h90;
	localparam logic [7:0] OP_TRIPLET = 8'h9F;
	// Identity values, arbitrary neutral choices
	localparam logic [7:0] ID_MAKER = 8'h5A;
	localparam logic [7:0] ID_DEVICE = 8'h12;
	localparam logic [7:0] ID_TYPE = 8'h40;
	localparam logic [7:0] ID_CAPACITY = 8'h13;
	// Status bit positions
	localparam int SR_WIP_BIT = 0;
	localparam int SR_WEL_BIT = 1;
	localparam int SR_BP_LSB = 2;
	// Default self-timed durations in timer clock cycles
	localparam int T_SMALL_CYC = 64;
	localparam int T_LARGE_CYC = 256;
	localparam int T_WHOLE_CYC = 1024;
	localparam int T_SLEEP_CYC = 8;
	localparam int T_WAKE1_CYC = 8;
	localparam int T_WAKE2_CYC = 16;
	// Host clock divider: link clock period = 2 * HALF * 20 ns
	localparam int HOST_HALF_DIV = 2;
	localparam int ADDR_W = 24;
endpackage

// >>> sfe_link_if.sv
// Interface joining host controller and flash device over the serial link
`timescale 1ns/100ps
interface sfe_link_if;
	logic sck;
	logic cs_n;
	logic serial_in_line;
	logic serial_out;
	logic serial_out_oe;
	modport host (output sck, output cs_n, output serial_in_line, input serial_out,
		input serial_out_oe);
	modport dev (input sck, input cs_n, input serial_in_line, output serial_out,
		output serial_out_oe);
endinterface

// >>> sfe_flash_dev.sv
// Flash device end: command decode, erase timing, sleep and identity readout
`timescale 1ns/100ps
module sfe_flash_dev
	import sfe_pkg::*;
#(
	parameter int T_SMALL = T_SMALL_CYC,
	parameter int T_LARGE = T_LARGE_CYC,
	parameter int T_WHOLE = T_WHOLE_CYC,
	parameter int T_SLEEP = T_SLEEP_CYC,
	parameter int T_WAKE1 = T_WAKE1_CYC,
	parameter int T_WAKE2 = T_WAKE2_CYC
) (
	// Link
	sfe_link_if.dev LNK,
	// Reset (power-on)
	input wire logic RST_I,
	// Free-running timer clock for self-timed cycles
	input wire logic TCLK_I,
	// Protection setting and status view
	input wire logic [3:0] BP_I,
	output logic WIP_O,
	output logic WEL_O,
	output logic SLEEP_O,
	output logic ERASE_PULSE_O,
	output logic [1:0] ERASE_KIND_O,
	output logic [23:0] ERASE_ADDR_O
);
	// Refuse timing counts the down-counter cannot serve
	if (T_SMALL < 1 || T_LARGE < 1 || T_WHOLE < 1 || T_SLEEP < 1 || T_WAKE1 < 1 ||
		T_WAKE2 < 1) begin : g_bad_timing
		$error("timing counts must be at least one");
	end

	typedef enum logic [1:0] {SFE_IDLE, SFE_BUSY, SFE_SLEEP, SFE_WAKING} sfe_pwr_t;

	// Protection: BP value n in 1..7 protects top 2^(n-1) 64 kB blocks, 8 and above every block; nonzero blocks whole array
	function automatic logic prot_hit(input logic [3:0] bp, input logic [23:0] a);
		logic [7:0] blk;
		blk = a[23:16];
		if (bp == 4'h0) prot_hit = 1'b0;
		else if (bp >= 4'h8) prot_hit = 1'b1;
		else prot_hit = (8'hFF - blk) < (8'h01 << (bp - 4'h1));
	endfunction

	// Front end on link clock: shift register and bit count per frame
	logic [31:0] sh_r;
	logic [5:0] cnt_r;
	logic [7:0] op_r;
	logic adr0_r;
	wire logic [31:0] sh_nxt = {sh_r[30:0], LNK.serial_in_line};
	always_ff @(posedge LNK.sck or posedge LNK.cs_n) begin
		if (LNK.cs_n) begin
			cnt_r <= 6'h00;
			sh_r <= 32'h0;
			op_r <= 8'h00;
			adr0_r <= 1'b0;
		end else begin
			sh_r <= sh_nxt;
			if (cnt_r != 6'h3F) cnt_r <= cnt_r + 6'h01;
			if (cnt_r == 6'h07) op_r <= sh_nxt[7:0];
			if (cnt_r == 6'h1F) adr0_r <= sh_nxt[0]; // Last address bit sets the id order
		end
	end

	// Output side: byte shifted on falling edge, MSB first
	logic [7:0] so_byte;
	logic [2:0] bit_idx;
	logic [7:0] state_r_view;
	sfe_pwr_t pwr_r;
	logic wel_r;
	logic [7:0] status_byte;
	assign status_byte = {2'b00, BP_I, wel_r, pwr_r == SFE_BUSY};
	wire logic busy = (pwr_r == SFE_BUSY);
	wire logic asleep = (pwr_r == SFE_SLEEP);
	wire logic [5:0] oc = cnt_r - 6'h08;
	wire logic [5:0] idc = cnt_r - 6'h20;
	always_comb begin
		so_byte = 8'h00;
		unique case (op_r)
			OP_RDSR: so_byte = status_byte;
			OP_WAKE: so_byte = ID_DEVICE;
			OP_MFDEV: so_byte = (idc[3] ^ adr0_r) ? ID_DEVICE : ID_MAKER;
			OP_TRIPLET: so_byte = (oc[5:3] == 3'd0) ? ID_MAKER :
				(oc[5:3] == 3'd1) ? ID_TYPE : ID_CAPACITY;
			default: so_byte = 8'h00;
		endcase
	end
	assign bit_idx = 3'd7 - cnt_r[2:0];
	assign state_r_view = so_byte;
	// Which command phase drives data out
	wire logic out_phase = !(asleep && op_r != OP_WAKE) && !(busy && op_r != OP_RDSR) &&
		((op_r == OP_RDSR && cnt_r >= 6'h08) || (op_r == OP_WAKE && cnt_r >= 6'h20) ||
		(op_r == OP_MFDEV && cnt_r >= 6'h20) || (op_r == OP_TRIPLET && cnt_r >= 6'h08 &&
		cnt_r < 6'h20));
	logic so_r;
	logic oe_r;
	always_ff @(negedge LNK.sck or posedge LNK.cs_n) begin
		if (LNK.cs_n) begin
			so_r <= 1'b0;
			oe_r <= 1'b0;
		end else begin
			so_r <= out_phase & state_r_view[bit_idx]; // Released line rests low
			oe_r <= out_phase;
		end
	end
	assign LNK.serial_out = so_r;
	assign LNK.serial_out_oe = oe_r;

	// Frame end decode: captured when select rises
	logic [7:0] fop;
	logic [5:0] fcnt;
	logic [23:0] fadr;
	assign fop = op_r;
	assign fcnt = cnt_r;
	assign fadr = sh_r[23:0];
	wire logic erase_frame = ((fop == OP_SMALL || fop == OP_LARGE) && fcnt == 6'h20) ||
		(fop == OP_WHOLE && fcnt == 6'h08);
	wire logic bp_any = (BP_I != 4'h0);
	wire logic prot = (fop == OP_WHOLE) ? bp_any : prot_hit(BP_I, fadr);

	// Frame capture held on select rise and its toggle toward the timer domain
	logic fe_tog_r;
	logic [7:0] c_op;
	logic [5:0] c_cnt;
	logic [23:0] c_adr;
	logic c_erase;
	logic c_prot;
	logic [1:0] c_kind;
	logic fe_tog_s1;
	logic fe_tog_s2;
	logic fe_tog_s3;

	// Timer and state, updated on free timer clock only; frame events arrive via toggle handshake
	logic [31:0] tmr_r;
	logic [1:0] kind_r;
	logic [23:0] eadr_r;
	logic ers_r;
	always_ff @(posedge TCLK_I or posedge RST_I) begin
		if (RST_I) begin
			pwr_r <= SFE_IDLE;
			wel_r <= 1'b0;
			tmr_r <= 32'h0;
			kind_r <= 2'b00;
			eadr_r <= 24'h0;
			ers_r <= 1'b0;
		end else begin
			ers_r <= 1'b0;
			if (fe_tog_s2 != fe_tog_s3) begin
				if (pwr_r == SFE_SLEEP) begin
					if (c_op == OP_WAKE && (c_cnt == 6'h08 || c_cnt >= 6'h20)) begin
						pwr_r <= SFE_WAKING;
						tmr_r <= (c_cnt == 6'h08) ? T_WAKE1 : T_WAKE2;
					end
				end else if (pwr_r != SFE_BUSY) begin
					if (c_op == OP_WREN && c_cnt == 6'h08) wel_r <= 1'b1;
					else if (c_erase && wel_r && !c_prot) begin
						pwr_r <= SFE_BUSY;
						kind_r <= c_kind;
						eadr_r <= c_adr;
						tmr_r <= (c_kind == 2'd0) ? T_SMALL : (c_kind == 2'd1) ? T_LARGE :
							T_WHOLE;
					end else if (c_op == OP_SLEEP && c_cnt == 6'h08) begin
						pwr_r <= SFE_WAKING;
						kind_r <= 2'd3;
						tmr_r <= T_SLEEP;
					end
				end
			end else if (tmr_r != 32'h0) begin
				tmr_r <= tmr_r - 32'h1;
			end else if (pwr_r == SFE_BUSY) begin
				pwr_r <= SFE_IDLE;
				wel_r <= 1'b0;
				ers_r <= 1'b1;
			end else if (pwr_r == SFE_WAKING) begin
				pwr_r <= (kind_r == 2'd3) ? SFE_SLEEP : SFE_IDLE;
				kind_r <= 2'd0;
			end
		end
	end

	// Frame capture on select rise with toggle toward timer domain
	always_ff @(posedge LNK.cs_n or posedge RST_I) begin
		if (RST_I) begin
			fe_tog_r <= 1'b0;
			c_op <= 8'h00;
			c_cnt <= 6'h00;
			c_adr <= 24'h0;
			c_erase <= 1'b0;
			c_prot <= 1'b0;
			c_kind <= 2'd0;
		end else begin
			fe_tog_r <= ~fe_tog_r;
			c_op <= fop;
			c_cnt <= fcnt;
			c_adr <= fadr;
			c_erase <= erase_frame;
			c_prot <= prot;
			c_kind <= (fop == OP_SMALL) ? 2'd0 : (fop == OP_LARGE) ? 2'd1 : 2'd2;
		end
	end
	// Two-stage synchroniser plus an edge stage for the frame toggle
	always_ff @(posedge TCLK_I or posedge RST_I) begin
		if (RST_I) begin
			fe_tog_s1 <= 1'b0;
			fe_tog_s2 <= 1'b0;
			fe_tog_s3 <= 1'b0;
		end else begin
			fe_tog_s1 <= fe_tog_r;
			fe_tog_s2 <= fe_tog_s1;
			fe_tog_s3 <= fe_tog_s2;
		end
	end

	// Status outputs
	assign WIP_O = busy;
	assign WEL_O = wel_r;
	assign SLEEP_O = asleep;
	assign ERASE_PULSE_O = ers_r;
	assign ERASE_KIND_O = kind_r;
	assign ERASE_ADDR_O = eadr_r;
endmodule

// >>> sfe_flash_host.sv
// Host controller end: divides its clock into the link clock and runs one frame per request
`timescale 1ns/100ps
module sfe_flash_host
	import sfe_pkg::*;
#(
	parameter int HALF = HOST_HALF_DIV
) (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RST_I,
	// Link
	sfe_link_if.host LNK,
	// Request
	input wire logic REQ_I,
	input wire logic [7:0] OP_I,
	input wire logic [5:0] NBITS_I,
	input wire logic [23:0] ADDR_I,
	output logic BUSY_O,
	output logic DONE_O,
	output logic [31:0] RDATA_O
);
	// Refuse divider values the 8-bit counter cannot serve
	if (HALF < 1 || HALF > 255) begin : g_bad_half
		$error("HALF out of range");
	end

	typedef enum logic [1:0] {SFH_IDLE, SFH_SHIFT, SFH_GAP} sfh_st_t;
	sfh_st_t st_r;
	logic [7:0] div_r;
	logic sck_r;
	logic [5:0] left_r;
	logic [31:0] tx_r;
	logic [31:0] rx_r;
	logic done_r;
	logic so_s1;
	logic so_s2;
	wire logic tick = (div_r == 8'(HALF - 1));

	// Serial data in synchroniser
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			so_s1 <= 1'b0;
			so_s2 <= 1'b0;
		end else begin
			so_s1 <= LNK.serial_out;
			so_s2 <= so_s1;
		end
	end

	// Frame sequencer: select low, NBITS_I bits, select high after last bit
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			st_r <= SFH_IDLE;
			div_r <= 8'h00;
			sck_r <= 1'b0;
			left_r <= 6'h00;
			tx_r <= 32'h0;
			rx_r <= 32'h0;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			div_r <= tick ? 8'h00 : div_r + 8'h01;
			unique case (st_r)
				SFH_IDLE: begin
					div_r <= 8'h00;
					if (REQ_I && NBITS_I != 6'h00) begin
						st_r <= SFH_SHIFT;
						left_r <= NBITS_I;
						tx_r <= {OP_I, ADDR_I};
					end
				end
				SFH_SHIFT: begin
					if (tick) begin
						sck_r <= ~sck_r;
						if (sck_r) begin
							// Synchroniser delay: so_s2 now shows the bit launched last fall
							rx_r <= {rx_r[30:0], so_s2};
							tx_r <= {tx_r[30:0], 1'b0};
							left_r <= left_r - 6'h01;
							if (left_r == 6'h01) st_r <= SFH_GAP;
						end
					end
				end
				SFH_GAP: begin
					if (tick) begin
						st_r <= SFH_IDLE;
						done_r <= 1'b1;
					end
				end
				default: st_r <= SFH_IDLE;
			endcase
		end
	end

	assign LNK.sck = sck_r;
	assign LNK.cs_n = (st_r != SFH_SHIFT);
	assign LNK.serial_in_line = tx_r[31];
	assign BUSY_O = (st_r != SFH_IDLE);
	assign DONE_O = done_r;
	assign RDATA_O = rx_r;
endmodule

// >>> sfe_link_assertions.sv
// Concurrent checks on the serial link between host and flash device
`timescale 1ns/100ps
module sfe_link_assertions (
	// Clock and reset
	input wire logic CLK_I,
	input wire logic RST_I,
	// Link signals
	input wire logic sck,
	input wire logic cs_n,
	input wire logic serial_in_line,
	input wire logic serial_out,
	input wire logic serial_out_oe
);
	default clocking cb @(posedge CLK_I);
	endclocking
	default disable iff (RST_I);
	// Link clock phases, two host cycles each
	sequence s_high;
		sck [*2] ##1 !sck;
	endsequence
	sequence s_low;
		!sck [*2];
	endsequence
	chk_sck_high_phase: assert property ($rose(sck) |-> s_high)
		else $error("link clock high phase wrong");
	chk_sck_low_phase: assert property ($fell(sck) |-> s_low)
		else $error("link clock low phase wrong");
	chk_idle_sck_low: assert property (cs_n |-> !sck)
		else $error("link clock moved while deselected");
	chk_end_after_bit: assert property ($rose(cs_n) |-> !sck && $past(sck))
		else $error("select rose inside a bit");
	chk_in_stable_high: assert property (
		sck && $past(sck) |-> $stable(serial_in_line))
		else $error("input line moved while clock high");
	chk_out_stable_high: assert property (
		serial_out_oe && sck && $past(sck) |-> $stable(serial_out))
		else $error("output line moved while clock high");
	chk_oe_off_idle: assert property (cs_n [*8] |-> !serial_out_oe)
		else $error("device drives while deselected");
	chk_oe_off_opcode: assert property ($fell(cs_n) |-> !serial_out_oe [*8])
		else $error("device drives during opcode");
	chk_out_rest_low: assert property (!serial_out_oe |-> !serial_out)
		else $error("output line active while released");
endmodule

// >>> test_spi_flash_erase_power_id.sv
// Testbench joining both link ends and checking commands over the link
`timescale 1ns/100ps
module test_spi_flash_erase_power_id;
	import sfe_pkg::*;
	logic clk = 1'b0;
	logic tclk = 1'b0;
	logic rst = 1'b1;
	logic req = 1'b0;
	logic [7:0] op = 8'h00;
	logic [5:0] nb = 6'h00;
	logic [23:0] ad = 24'h000000;
	logic [3:0] bp = 4'h0;
	logic busy, done, write_in_progress, write_enable_latch, slp, ep;
	logic [1:0] ek;
	logic [23:0] ea;
	logic [31:0] rd;
	int failures = 0;
	int check_count = 0;
	int i;
	logic [7:0] eop [3] = '{OP_SMALL, OP_LARGE, OP_WHOLE};
	logic [5:0] enb [3] = '{6'h20, 6'h20, 6'h08};
	logic [23:0] ead [3] = '{24'h012000, 24'h030000, 24'h000000};
	// Link and both ends
	sfe_link_if lnk ();
	sfe_flash_host sfe_flash_host_i (.CLK_I(clk), .RST_I(rst), .LNK(lnk), .REQ_I(req), .OP_I(op),
		.NBITS_I(nb), .ADDR_I(ad), .BUSY_O(busy), .DONE_O(done), .RDATA_O(rd));
	sfe_flash_dev #(.T_SMALL(600), .T_LARGE(700), .T_WHOLE(800), .T_SLEEP(4),
		.T_WAKE1(4)) sfe_flash_dev_i (.LNK(lnk), .RST_I(rst), .TCLK_I(tclk), .BP_I(bp),
		.WIP_O(write_in_progress), .WEL_O(write_enable_latch), .SLEEP_O(slp), .ERASE_PULSE_O(ep), .ERASE_KIND_O(ek),
		.ERASE_ADDR_O(ea));
	sfe_link_assertions sfe_link_assertions_i (.CLK_I(clk), .RST_I(rst), .sck(lnk.sck),
		.cs_n(lnk.cs_n), .serial_in_line(lnk.serial_in_line), .serial_out(lnk.serial_out),
		.serial_out_oe(lnk.serial_out_oe));
	// Host clock 20 ns, timer clock 64 ns with offset phase
	initial begin
		forever #10 clk = ~clk;
	end
	initial begin
		#7;
		forever #32 tclk = ~tclk;
	end
	task automatic report_and_stop();
		if (failures == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic give_up(input logic ok);
		if (ok !== 1'b1) begin
			failures++;
			report_and_stop();
		end
	endtask
	// Gap long enough for the device state update and the longest wake delay
	task automatic gap();
		repeat (100) @(posedge clk);
		#1;
	endtask
	task automatic frame(input logic [7:0] o, input logic [5:0] n, input logic [23:0] a);
		int k;
		op = o;
		nb = n;
		ad = a;
		req = 1'b1;
		@(posedge clk);
		#1 req = 1'b0;
		for (k = 0; k < 400 && done !== 1'b1; k++) begin
			@(posedge clk);
			#1;
		end
		give_up(done);
		check("host idle", busy, 1'b0);
		gap();
	endtask
	task automatic wait_erase(input logic [1:0] kind, input logic [23:0] a);
		int k;
		for (k = 0; k < 1000 && ep !== 1'b1; k++) @(negedge tclk);
		give_up(ep);
		check("erase kind", ek, kind);
		if (kind != 2'h2) check("erase addr", ea, a);
		gap();
	endtask
	// Main sequence
	initial begin
		repeat (8) @(posedge clk);
		#1 rst = 1'b0;
		check("idle", {write_in_progress, write_enable_latch, slp}, 3'h0);
		frame(OP_RDSR, 6'h10, 24'h0);
		check("status", rd[7:0], 8'h00);
		frame(OP_SMALL, 6'h20, 24'h001000);
		check("no latch", write_in_progress, 1'b0);
		for (i = 0; i < 3; i++) begin
			frame(OP_WREN, 6'h08, 24'h0);
			frame(eop[i], enb[i], ead[i]);
			check("busy", {write_in_progress, write_enable_latch}, 2'h3);
			frame(OP_RDSR, 6'h10, 24'h0);
			check("poll", rd[1:0], 2'h3);
			wait_erase(2'(i), ead[i]);
			check("after", {write_in_progress, write_enable_latch}, 2'h0);
		end
		frame(OP_WREN, 6'h08, 24'h0);
		frame(OP_SMALL, 6'h21, 24'h001000);
		check("bit count", write_in_progress, 1'b0);
		bp = 4'hF;
		frame(OP_LARGE, 6'h20, 24'h010000);
		check("prot region", write_in_progress, 1'b0);
		bp = 4'h1;
		frame(OP_WHOLE, 6'h08, 24'h0);
		check("prot whole", write_in_progress, 1'b0);
		bp = 4'h0;
		frame(OP_WREN, 6'h08, 24'h0);
		frame(OP_SMALL, 6'h20, 24'h002000);
		frame(OP_SLEEP, 6'h08, 24'h0);
		frame(OP_READ, 6'h28, 24'h002000);
		frame(OP_WAKE, 6'h08, 24'h0);
		check("busy sleep", {write_in_progress, slp}, 2'h2);
		wait_erase(2'h0, 24'h002000);
		frame(OP_SLEEP, 6'h09, 24'h0);
		check("sleep count", slp, 1'b0);
		frame(OP_WREN, 6'h08, 24'h0);
		frame(OP_SLEEP, 6'h08, 24'h0);
		check("asleep", slp, 1'b1);
		frame(OP_SMALL, 6'h20, 24'h003000);
		check("ignored", write_in_progress, 1'b0);
		frame(OP_RDSR, 6'h10, 24'h0);
		check("sleep status", rd[7:0], 8'h00);
		frame(OP_WAKE, 6'h08, 24'h0);
		check("awake", slp, 1'b0);
		frame(OP_RDSR, 6'h10, 24'h0);
		check("awake status", rd[7:0], 8'(1 << SR_WEL_BIT));
		frame(OP_SLEEP, 6'h08, 24'h0);
		frame(OP_WAKE, 6'h30, 24'h0);
		check("wake id", {slp, rd[15:0]}, {1'b0, ID_DEVICE, ID_DEVICE});
		frame(OP_MFDEV, 6'h30, 24'h000000);
		check("maker dev", rd[15:0], {ID_MAKER, ID_DEVICE});
		frame(OP_MFDEV, 6'h30, 24'h000001);
		check("dev maker", rd[15:0], {ID_DEVICE, ID_MAKER});
		frame(OP_TRIPLET, 6'h20, 24'h0);
		check("triplet", rd[23:0], {ID_MAKER, ID_TYPE, ID_CAPACITY});
		report_and_stop();
	end
endmodule
